// ==== rtl/cid_pkg.sv ====
// Purpose: Shared constants and types of the instruction decoder
// Assumes: 32-bit fetch word, first opcode byte in the low byte
// Notes:   Opcode map contents are loaded at run time
// Overview of operation
// - Add and subtract, with or without carry, decode as 2 or 4 bytes
// - Multiply is 2 bytes, two direct registers, 16 by 16 bit
// - Short divide is 2 bytes, low muldiv register by direct register
// - Long divide is 2 bytes, 32-bit muldiv pair by 16-bit register
// - Complement and negate are 2 bytes, in place on one register
// - AND, OR, XOR take word or byte operands, 2 or 4 bytes
// - Bit move is 4 bytes, copies a bit, optionally inverted
// - Bit AND, OR, XOR are 4 bytes, combine two direct bits
// - Bit compare is 4 bytes, sets flags, changes neither bit
// - Masked field ops are 4 bytes, modify high or low byte
// - Compare and decrement by 1 or 2, 2 or 4 bytes
// - Compare and increment by 1 or 2, 2 or 4 bytes
// - Normalise count is 2 bytes, writes shift count to a register
// - Rotate left and right of a direct register are 2 bytes
// - Arithmetic shift right is 2 bytes, sign bit replicated
// - Byte to word move widens with sign or zero, 2 or 4 bytes
// - Bit test jumps are 4 bytes, may also clear or set the bit
// - Push and call is 4 bytes, push register then call
// - Context switch is 4 bytes, push register then load it
// - Software trap is 2 bytes, vectors by immediate trap number
// - Near return is 2 bytes, popping form restores a register
// - Page and segment prefixes are 2 or 4 bytes, start a sequence
// - Unused power-down decodes as valid but has no effect
package cid_pkg;

  // ****************************************************************
  // Instruction word fields
  // ****************************************************************
  localparam int OPC_LSB      = 0;
  localparam int OPC_W        = 8;
  localparam int SRC_LSB      = 8;
  localparam int DST_LSB      = 12;
  localparam int REG_W        = 4;
  localparam int TRAP_LSB     = 9;
  localparam int TRAP_W       = 7;
  localparam int EXT_LSB      = 16;
  localparam int EXT_W        = 16;

  // ****************************************************************
  // Opcode map entry layout
  // ****************************************************************
  localparam int ENT_W        = 14;
  localparam int ENT_VAR_LSB  = 0;
  localparam int ENT_BYTE     = 2;
  localparam int ENT_LEN4     = 3;
  localparam int ENT_FORM_LSB = 4;
  localparam int ENT_CLS_LSB  = 7;
  localparam int ENT_VALID    = 13;

  // ****************************************************************
  // Lengths and steps
  // ****************************************************************
  localparam logic [2:0] LEN_SHORT   = 3'h2;
  localparam logic [2:0] LEN_LONG    = 3'h4;
  localparam logic [1:0] STEP_NONE   = 2'h0;
  localparam logic [1:0] STEP_ONE    = 2'h1;
  localparam logic [1:0] STEP_TWO    = 2'h2;
  localparam logic [1:0] MULDIV_NONE = 2'h0;
  localparam logic [1:0] MULDIV_LOW  = 2'h1;
  localparam logic [1:0] MULDIV_PAIR = 2'h2;

  typedef enum logic [5:0] {
    c_other, c_add, c_add_carry, c_sub, c_sub_carry, c_multiply,
    c_divide, c_long_divide, c_complement, c_negate, c_and, c_or,
    c_xor, c_bit_move, c_bit_logic, c_bit_compare, c_masked_field,
    c_cmp_dec, c_cmp_inc, c_normalise, c_rotate, c_arith_shr,
    c_byte_widen, c_jump_bit_set, c_jump_bit_clear, c_push_call,
    c_context_switch, c_trap, c_near_return, c_page_prefix,
    c_segment_prefix, c_powerdown
  } cid_class_type;

  typedef enum logic [2:0] {
    f_none, f_reg_reg, f_reg_imm, f_reg_mem, f_bit_bit,
    f_word_mask, f_reg_only, f_imm_only
  } cid_form_type;

  typedef enum logic [4:0] {
    a_none, a_add, a_sub, a_mult, a_div, a_not, a_negate, a_and, a_or,
    a_xor, a_move, a_cmp, a_norm, a_rotl, a_rotr, a_shr_sign, a_field
  } cid_alu_type;

endpackage

// ==== rtl/cid_opmap.sv ====
// Purpose: Loadable opcode map, one entry per first opcode byte
// Assumes: Loaded by software or boot logic before decoding
// Notes:   Cleared on reset so unloaded opcodes decode as illegal
`timescale 1ns/100ps
module cid_opmap #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 14
) (
  // Clock and control
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  // Load port
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  // Lookup port
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data
);

  typedef struct packed {
    logic [(1<<ADDR_W)-1:0][DATA_W-1:0] mem;
    logic [DATA_W-1:0]                  rd;
  } cid_map_type;

  cid_map_type r;
  cid_map_type next_r;

  always_comb begin
    next_r = r;
    next_r.rd = r.mem[rd_addr];
    if (wr_en) begin
      next_r.mem[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      r <= '0;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign rd_data = r.rd;

endmodule

// ==== rtl/cid_semantics.sv ====
// Purpose: Map class and variant to datapath operation controls
// Assumes: Variant bit 0 selects the alternate form of each class but bit logic, which uses both variant bits
// Notes:   Purely combinational; the top registers every result
`timescale 1ns/100ps
module cid_semantics (
  // Decoded entry
  input  wire cid_pkg::cid_class_type cls,
  input  wire logic [1:0]             variant,
  // Datapath controls
  output cid_pkg::cid_alu_type        alu_op,
  output logic                        use_carry,
  output logic                        signed_op,
  output logic                        extend_sign,
  output logic [1:0]                  step,
  output logic                        step_up,
  output logic                        flags_only,
  output logic                        bit_invert,
  output logic                        bit_modify,
  output logic                        bit_value,
  output logic                        branch_on_set,
  output logic                        push_first,
  output logic                        pop_reg,
  output logic                        prefix_start,
  output logic                        prefix_segment,
  output logic                        prefix_regmode,
  output logic [1:0]                  muldiv_src,
  output logic                        no_effect,
  output logic                        trap
);

  always_comb begin
    alu_op = cid_pkg::a_none;
    use_carry = 1'b0;
    signed_op = !variant[0];
    extend_sign = 1'b0;
    step = cid_pkg::STEP_NONE;
    step_up = 1'b0;
    flags_only = 1'b0;
    bit_invert = 1'b0;
    bit_modify = 1'b0;
    bit_value = 1'b0;
    branch_on_set = 1'b0;
    push_first = 1'b0;
    pop_reg = 1'b0;
    prefix_start = 1'b0;
    prefix_segment = 1'b0;
    prefix_regmode = 1'b0;
    muldiv_src = cid_pkg::MULDIV_NONE;
    no_effect = 1'b0;
    trap = 1'b0;
    case (cls)
      cid_pkg::c_add: alu_op = cid_pkg::a_add;
      cid_pkg::c_add_carry: begin
        alu_op = cid_pkg::a_add;
        use_carry = 1'b1;
      end
      cid_pkg::c_sub: alu_op = cid_pkg::a_sub;
      cid_pkg::c_sub_carry: begin
        alu_op = cid_pkg::a_sub;
        use_carry = 1'b1;
      end
      cid_pkg::c_multiply: alu_op = cid_pkg::a_mult;
      cid_pkg::c_divide: begin
        alu_op = cid_pkg::a_div;
        muldiv_src = cid_pkg::MULDIV_LOW;
      end
      cid_pkg::c_long_divide: begin
        alu_op = cid_pkg::a_div;
        muldiv_src = cid_pkg::MULDIV_PAIR;
      end
      cid_pkg::c_complement: alu_op = cid_pkg::a_not;
      cid_pkg::c_negate: alu_op = cid_pkg::a_negate;
      cid_pkg::c_and: alu_op = cid_pkg::a_and;
      cid_pkg::c_or: alu_op = cid_pkg::a_or;
      cid_pkg::c_xor: alu_op = cid_pkg::a_xor;
      cid_pkg::c_bit_move: begin
        alu_op = cid_pkg::a_move;
        bit_invert = variant[0];
      end
      cid_pkg::c_bit_logic: begin
        if (variant == 2'h0) begin
          alu_op = cid_pkg::a_and;
        end else if (variant == 2'h1) begin
          alu_op = cid_pkg::a_or;
        end else begin
          alu_op = cid_pkg::a_xor;
        end
      end
      cid_pkg::c_bit_compare: begin
        alu_op = cid_pkg::a_cmp;
        flags_only = 1'b1;
      end
      cid_pkg::c_masked_field: begin
        alu_op = cid_pkg::a_field;
        bit_value = variant[0]; // High byte when set
      end
      cid_pkg::c_cmp_dec, cid_pkg::c_cmp_inc: begin
        alu_op = cid_pkg::a_cmp;
        step = variant[0] ? cid_pkg::STEP_TWO : cid_pkg::STEP_ONE;
        step_up = (cls == cid_pkg::c_cmp_inc);
      end
      cid_pkg::c_normalise: alu_op = cid_pkg::a_norm;
      cid_pkg::c_rotate: begin
        alu_op = variant[0] ? cid_pkg::a_rotr : cid_pkg::a_rotl;
      end
      cid_pkg::c_arith_shr: alu_op = cid_pkg::a_shr_sign;
      cid_pkg::c_byte_widen: begin
        alu_op = cid_pkg::a_move;
        extend_sign = !variant[0];
      end
      cid_pkg::c_jump_bit_set, cid_pkg::c_jump_bit_clear: begin
        branch_on_set = (cls == cid_pkg::c_jump_bit_set);
        bit_modify = variant[0];
        // Set-branch clears the bit, clear-branch sets it
        bit_value = !branch_on_set;
      end
      cid_pkg::c_push_call: push_first = 1'b1;
      cid_pkg::c_context_switch: begin
        push_first = 1'b1;
        alu_op = cid_pkg::a_move;
      end
      cid_pkg::c_trap: trap = 1'b1;
      cid_pkg::c_near_return: pop_reg = variant[0];
      cid_pkg::c_page_prefix, cid_pkg::c_segment_prefix: begin
        prefix_start = 1'b1;
        prefix_segment = (cls == cid_pkg::c_segment_prefix);
        prefix_regmode = variant[0];
      end
      cid_pkg::c_powerdown: no_effect = 1'b1;
      default: alu_op = cid_pkg::a_none;
    endcase
  end

endmodule

// ==== rtl/cid_decoder.sv ====
// Purpose: Instruction decode and length classification
// Assumes: Fetch and execute stages on the same clock as the decoder
// Notes:   One instruction in flight; at best a new one every three cycles, more when decode_ready stalls
`timescale 1ns/100ps
module cid_decoder #(
  parameter int OPC_W = cid_pkg::OPC_W,
  parameter int ENT_W = cid_pkg::ENT_W
) (
  // Clock, reset, enable
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic                   clk_en,
  // Fetch side
  input  wire logic                   fetch_valid,
  input  wire logic [31:0]            fetch_word,
  output logic                        fetch_ready,
  // Opcode map load
  input  wire logic                   table_wr_en,
  input  wire logic [OPC_W-1:0]       table_wr_addr,
  input  wire logic [ENT_W-1:0]       table_wr_data,
  // Decode result
  output logic                        decode_valid,
  input  wire logic                   decode_ready,
  output cid_pkg::cid_class_type      dec_class,
  output cid_pkg::cid_form_type       dec_form,
  output logic [2:0]                  dec_len,
  output logic                        dec_illegal,
  output logic                        dec_byte_op,
  output logic [cid_pkg::REG_W-1:0]   dec_dst_reg,
  output logic [cid_pkg::REG_W-1:0]   dec_src_reg,
  output logic [cid_pkg::EXT_W-1:0]   dec_ext_word,
  output logic [cid_pkg::TRAP_W-1:0]  dec_trap_num,
  // Datapath controls
  output cid_pkg::cid_alu_type        dec_alu_op,
  output logic                        dec_use_carry,
  output logic                        dec_signed,
  output logic                        dec_extend_sign,
  output logic [1:0]                  dec_step,
  output logic                        dec_step_up,
  output logic                        dec_flags_only,
  output logic                        dec_bit_invert,
  output logic                        dec_bit_modify,
  output logic                        dec_bit_value,
  output logic                        dec_branch_on_set,
  output logic                        dec_push_first,
  output logic                        dec_pop_reg,
  output logic                        dec_prefix_start,
  output logic                        dec_prefix_segment,
  output logic                        dec_prefix_regmode,
  output logic [1:0]                  dec_muldiv_src,
  output logic                        dec_no_effect,
  output logic                        dec_trap
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [1:0] {
    s_idle, s_lookup, s_present
  } cid_state_type;

  typedef struct packed {
    cid_state_type                state;
    logic [31:0]                  word;
    logic                         ready;
    logic                         valid;
    cid_pkg::cid_class_type       cls;
    cid_pkg::cid_form_type        form;
    logic [2:0]                   len;
    logic                         illegal;
    logic                         byte_op;
    logic [cid_pkg::REG_W-1:0]    dst;
    logic [cid_pkg::REG_W-1:0]    src;
    logic [cid_pkg::EXT_W-1:0]    ext;
    logic [cid_pkg::TRAP_W-1:0]   trapn;
    cid_pkg::cid_alu_type         alu;
    logic                         carry;
    logic                         sgn;
    logic                         sext;
    logic [1:0]                   step;
    logic                         step_up;
    logic                         flags_only;
    logic                         binv;
    logic                         bmod;
    logic                         bval;
    logic                         bset;
    logic                         push;
    logic                         pop;
    logic                         pfx;
    logic                         pfx_seg;
    logic                         pfx_reg;
    logic [1:0]                   muldiv;
    logic                         noeff;
    logic                         trap;
  } cid_dec_type;

  cid_dec_type r;
  cid_dec_type next_r;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Documented length wins over the map, so a bad map entry
  // cannot desynchronise the fetch pointer for fixed classes
  function automatic logic [2:0] class_len(
    input cid_pkg::cid_class_type c,
    input logic                   len4
  );
    case (c)
      cid_pkg::c_multiply, cid_pkg::c_divide,
      cid_pkg::c_long_divide, cid_pkg::c_complement,
      cid_pkg::c_negate, cid_pkg::c_normalise,
      cid_pkg::c_rotate, cid_pkg::c_arith_shr,
      cid_pkg::c_trap, cid_pkg::c_near_return: begin
        class_len = cid_pkg::LEN_SHORT;
      end
      cid_pkg::c_bit_move, cid_pkg::c_bit_logic,
      cid_pkg::c_bit_compare, cid_pkg::c_masked_field,
      cid_pkg::c_jump_bit_set, cid_pkg::c_jump_bit_clear,
      cid_pkg::c_push_call, cid_pkg::c_context_switch,
      cid_pkg::c_powerdown: begin
        class_len = cid_pkg::LEN_LONG;
      end
      default: begin
        // Variable-length classes follow the map
        class_len = len4 ? cid_pkg::LEN_LONG : cid_pkg::LEN_SHORT;
      end
    endcase
  endfunction

  function automatic logic [cid_pkg::REG_W-1:0] reg_field(
    input logic [31:0] w,
    input int          lsb
  );
    reg_field = w[lsb +: cid_pkg::REG_W];
  endfunction

  // ****************************************************************
  // Opcode map and semantics
  // ****************************************************************
  logic [ENT_W-1:0]       entry;
  cid_pkg::cid_class_type ent_cls;
  cid_pkg::cid_alu_type   sem_alu;
  logic                   sem_carry;
  logic                   sem_sgn;
  logic                   sem_sext;
  logic [1:0]             sem_step;
  logic                   sem_step_up;
  logic                   sem_flags;
  logic                   sem_binv;
  logic                   sem_bmod;
  logic                   sem_bval;
  logic                   sem_bset;
  logic                   sem_push;
  logic                   sem_pop;
  logic                   sem_pfx;
  logic                   sem_pfx_seg;
  logic                   sem_pfx_reg;
  logic [1:0]             sem_muldiv;
  logic                   sem_noeff;
  logic                   sem_trap;

  cid_opmap #(
    .ADDR_W (OPC_W),
    .DATA_W (ENT_W)
  ) u_opmap (
    .clk     (clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .wr_en   (table_wr_en),
    .wr_addr (table_wr_addr),
    .wr_data (table_wr_data),
    .rd_addr (fetch_word[cid_pkg::OPC_LSB +: OPC_W]),
    .rd_data (entry)
  );

  assign ent_cls = cid_pkg::cid_class_type'(
    entry[cid_pkg::ENT_CLS_LSB +: 6]);

  cid_semantics u_sem (
    .cls            (ent_cls),
    .variant        (entry[cid_pkg::ENT_VAR_LSB +: 2]),
    .alu_op         (sem_alu),
    .use_carry      (sem_carry),
    .signed_op      (sem_sgn),
    .extend_sign    (sem_sext),
    .step           (sem_step),
    .step_up        (sem_step_up),
    .flags_only     (sem_flags),
    .bit_invert     (sem_binv),
    .bit_modify     (sem_bmod),
    .bit_value      (sem_bval),
    .branch_on_set  (sem_bset),
    .push_first     (sem_push),
    .pop_reg        (sem_pop),
    .prefix_start   (sem_pfx),
    .prefix_segment (sem_pfx_seg),
    .prefix_regmode (sem_pfx_reg),
    .muldiv_src     (sem_muldiv),
    .no_effect      (sem_noeff),
    .trap           (sem_trap)
  );

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  always_comb begin
    next_r = r;
    case (r.state)
      s_idle: begin
        if (fetch_valid) begin
          // Map read is issued from the live fetch word this cycle
          next_r.word = fetch_word;
          next_r.ready = 1'b0;
          next_r.state = s_lookup;
        end
      end
      s_lookup: begin
        next_r.illegal = !entry[cid_pkg::ENT_VALID];
        next_r.cls = entry[cid_pkg::ENT_VALID] ? ent_cls
                                                : cid_pkg::c_other;
        next_r.form = cid_pkg::cid_form_type'(
          entry[cid_pkg::ENT_FORM_LSB +: 3]);
        next_r.len = class_len(ent_cls,
          entry[cid_pkg::ENT_LEN4]);
        next_r.byte_op = entry[cid_pkg::ENT_BYTE];
        next_r.dst = reg_field(r.word, cid_pkg::DST_LSB);
        next_r.src = reg_field(r.word, cid_pkg::SRC_LSB);
        next_r.ext = r.word[cid_pkg::EXT_LSB +: cid_pkg::EXT_W];
        next_r.trapn = r.word[cid_pkg::TRAP_LSB +: cid_pkg::TRAP_W];
        next_r.alu = sem_alu;
        next_r.carry = sem_carry;
        next_r.sgn = sem_sgn;
        next_r.sext = sem_sext;
        next_r.step = sem_step;
        next_r.step_up = sem_step_up;
        next_r.flags_only = sem_flags;
        next_r.binv = sem_binv;
        next_r.bmod = sem_bmod;
        next_r.bval = sem_bval;
        next_r.bset = sem_bset;
        next_r.push = sem_push;
        next_r.pop = sem_pop;
        next_r.pfx = sem_pfx;
        next_r.pfx_seg = sem_pfx_seg;
        next_r.pfx_reg = sem_pfx_reg;
        next_r.muldiv = sem_muldiv;
        next_r.noeff = sem_noeff;
        next_r.trap = sem_trap;
        next_r.valid = 1'b1;
        next_r.state = s_present;
      end
      s_present: begin
        if (decode_ready) begin
          next_r.valid = 1'b0;
          next_r.ready = 1'b1;
          next_r.state = s_idle;
        end
      end
      default: next_r.state = s_idle;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      r <= '0;
      r.ready <= 1'b1;
      r.state <= s_idle;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign fetch_ready = r.ready;
  assign decode_valid = r.valid;
  assign dec_class = r.cls;
  assign dec_form = r.form;
  assign dec_len = r.len;
  assign dec_illegal = r.illegal;
  assign dec_byte_op = r.byte_op;
  assign dec_dst_reg = r.dst;
  assign dec_src_reg = r.src;
  assign dec_ext_word = r.ext;
  assign dec_trap_num = r.trapn;
  assign dec_alu_op = r.alu;
  assign dec_use_carry = r.carry;
  assign dec_signed = r.sgn;
  assign dec_extend_sign = r.sext;
  assign dec_step = r.step;
  assign dec_step_up = r.step_up;
  assign dec_flags_only = r.flags_only;
  assign dec_bit_invert = r.binv;
  assign dec_bit_modify = r.bmod;
  assign dec_bit_value = r.bval;
  assign dec_branch_on_set = r.bset;
  assign dec_push_first = r.push;
  assign dec_pop_reg = r.pop;
  assign dec_prefix_start = r.pfx;
  assign dec_prefix_segment = r.pfx_seg;
  assign dec_prefix_regmode = r.pfx_reg;
  assign dec_muldiv_src = r.muldiv;
  assign dec_no_effect = r.noeff;
  assign dec_trap = r.trap;

endmodule

// ==== sim/cid_decoder_chk.sv ====
// Purpose: Handshake and decode checks at the decoder ports
// Assumes: clk_en held high while checks run
// Notes:   Bound into every cid_decoder
`timescale 1ns/100ps
module cid_decoder_chk (
  // Clock and control
  input wire logic                   clk,
  input wire logic                   reset_n,
  input wire logic                   clk_en,
  // Handshakes
  input wire logic                   fetch_valid,
  input wire logic                   fetch_ready,
  input wire logic                   decode_valid,
  input wire logic                   decode_ready,
  // Result
  input wire cid_pkg::cid_class_type dec_class,
  input wire logic [2:0]             dec_len,
  input wire logic                   dec_use_carry,
  input wire logic                   dec_no_effect,
  input wire cid_pkg::cid_alu_type   dec_alu_op,
  input wire logic [1:0]             dec_muldiv_src
);
  default clocking @(posedge clk); endclocking
  // A frozen clock enable stretches every timing figure
  default disable iff (!reset_n || !clk_en);
  a_answer_two_edges: assert property (fetch_valid && fetch_ready |=>
    !decode_valid ##1 decode_valid) else $error("answer timing wrong");
  a_result_holds: assert property (decode_valid && !decode_ready |=>
    decode_valid && $stable(dec_class) && $stable(dec_len))
    else $error("result changed while stalled");
  a_release_ready: assert property (decode_valid && decode_ready |=>
    !decode_valid && fetch_ready) else $error("release wrong");
  a_busy_refuse: assert property (decode_valid |-> !fetch_ready)
    else $error("fetch ready while busy");
  a_muldiv_short: assert property (decode_valid && dec_class inside
    {cid_pkg::c_multiply, cid_pkg::c_divide, cid_pkg::c_long_divide}
    |-> dec_len == 3'h2) else $error("muldiv length wrong");
  a_bit_ops_long: assert property (decode_valid && dec_class inside
    {cid_pkg::c_bit_move, cid_pkg::c_bit_logic, cid_pkg::c_bit_compare,
    cid_pkg::c_masked_field} |-> dec_len == 3'h4)
    else $error("bit op length wrong");
  a_carry_used: assert property (decode_valid && dec_class inside
    {cid_pkg::c_add_carry, cid_pkg::c_sub_carry} |-> dec_use_carry)
    else $error("carry not used");
  a_pd_no_effect: assert property (decode_valid &&
    dec_class == cid_pkg::c_powerdown |-> dec_no_effect &&
    dec_alu_op == cid_pkg::a_none) else $error("power-down has effect");
  a_long_div_pair: assert property (decode_valid &&
    dec_class == cid_pkg::c_long_divide |-> dec_muldiv_src == 2'h2)
    else $error("long divide source wrong");
  c_stall: cover property (decode_valid && !decode_ready);
  c_pd: cover property (decode_valid && dec_class == cid_pkg::c_powerdown);
  c_take: cover property (fetch_valid && fetch_ready);
endmodule
bind cid_decoder cid_decoder_chk u_chk (.clk(clk), .reset_n(reset_n),
  .clk_en(clk_en), .fetch_valid(fetch_valid), .fetch_ready(fetch_ready),
  .decode_valid(decode_valid), .decode_ready(decode_ready),
  .dec_class(dec_class), .dec_len(dec_len), .dec_use_carry(dec_use_carry),
  .dec_no_effect(dec_no_effect), .dec_alu_op(dec_alu_op),
  .dec_muldiv_src(dec_muldiv_src));

// ==== sim/cid_exec_model.sv ====
// Purpose: Execute stage that takes decode results
// Assumes: Stall count set by the bench between decodes
// Notes:   Ready follows valid after stall cycles
`timescale 1ns/100ps
module cid_exec_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Result handshake
  input  wire logic       decode_valid,
  input  wire logic [3:0] stall,
  output logic            decode_ready
);
  logic [3:0] wait_cnt;
  always_ff @(posedge clk) begin
    if (!reset_n || !decode_valid) wait_cnt <= 4'h0;
    else if (!decode_ready) wait_cnt <= wait_cnt + 4'h1;
  end
  assign decode_ready = decode_valid && (wait_cnt >= stall);
endmodule

// ==== sim/test_cid_decoder.sv ====
// Purpose: Self-checking bench of the instruction decoder
// Assumes: clk_en held high throughout
// Notes:   Map loaded by the bench before decoding
`timescale 1ns/100ps
module test_cid_decoder;
  logic clk = 0, reset_n = 0, clk_en = 1, fetch_valid = 0, wr_en = 0;
  logic fetch_ready, decode_valid, decode_ready, illegal, carry, noeff;
  logic [31:0] fetch_word = 32'h0000_0000;
  logic [7:0] wr_addr = 8'h00;
  logic [13:0] wr_data = 14'h0000;
  logic [3:0] stall = 4'h0;
  logic [2:0] len;
  logic [1:0] step, mdsrc;
  logic sgn, up;
  cid_pkg::cid_class_type cls;
  int num_errors = 0, checked = 0, cycles = 0, n;
  always #10 clk = ~clk;
  cid_exec_model u_exec (.clk(clk), .reset_n(reset_n),
    .decode_valid(decode_valid), .stall(stall), .decode_ready(decode_ready));
  cid_decoder uut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .fetch_valid(fetch_valid), .fetch_word(fetch_word),
    .fetch_ready(fetch_ready), .table_wr_en(wr_en),
    .table_wr_addr(wr_addr), .table_wr_data(wr_data),
    .decode_valid(decode_valid), .decode_ready(decode_ready),
    .dec_class(cls), .dec_form(), .dec_len(len), .dec_illegal(illegal),
    .dec_byte_op(), .dec_dst_reg(), .dec_src_reg(), .dec_ext_word(),
    .dec_trap_num(), .dec_alu_op(), .dec_use_carry(carry),
    .dec_signed(sgn), .dec_extend_sign(), .dec_step(step),
    .dec_step_up(up), .dec_flags_only(), .dec_bit_invert(),
    .dec_bit_modify(), .dec_bit_value(), .dec_branch_on_set(),
    .dec_push_first(), .dec_pop_reg(), .dec_prefix_start(),
    .dec_prefix_segment(), .dec_prefix_regmode(),
    .dec_muldiv_src(mdsrc), .dec_no_effect(noeff), .dec_trap());
  task automatic test_done();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Hang guard well above the few hundred cycles used
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic chk(input string what, input logic [7:0] e, g);
    checked++;
    if (e !== g) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [5:0] c,
                    input logic l4, input logic [1:0] v);
    @(posedge clk); #1; wr_en = 1; wr_addr = a;
    wr_data = {1'b1, c, 3'h1, l4, 1'b0, v};
    @(posedge clk); #1; wr_en = 0;
  endtask
  // Total edges from take to release come back in n
  task automatic dec(input logic [7:0] op);
    @(posedge clk); #1; fetch_valid = 1; fetch_word = {24'h1234_5A, op};
    @(posedge clk); #1; fetch_valid = 0; n = 1;
    while (!decode_valid && n < 50) begin @(posedge clk); #1; n++; end
    chk("answer_edges", 8'h02, n[7:0]);
    while (decode_valid && n < 80) begin @(posedge clk); #1; n++; end
  endtask
  task automatic t_lengths();
    logic [2:0] e;
    for (int c = 1; c < 32; c++) for (int l = 0; l < 2; l++) begin
      wr({1'b0, l[0], c[5:0]}, c[5:0], l[0], 2'h0);
      dec({1'b0, l[0], c[5:0]});
      e = l ? 3'h4 : 3'h2;
      if (c inside {[5:9], [19:21], 27, 28}) e = 3'h2;
      if (c inside {[13:16], [23:26], 31}) e = 3'h4;
      chk("class", 8'(c), 8'(cls));
      chk("length", 8'(e), 8'(len));
    end
  endtask
  task automatic t_variants();
    wr(8'h82, 6'd2, 1'b1, 2'h1); dec(8'h82);
    chk("carry", 8'h01, 8'(carry));
    wr(8'h86, 6'd6, 1'b0, 2'h1); dec(8'h86);
    chk("div_src", 8'h01, 8'(mdsrc));
    chk("div_signed", 8'h00, 8'(sgn));
    wr(8'h91, 6'd17, 1'b0, 2'h1); dec(8'h91);
    chk("dec_step", 8'h02, 8'(step));
    chk("dec_up", 8'h00, 8'(up));
    wr(8'h92, 6'd18, 1'b0, 2'h0); dec(8'h92);
    chk("inc_step", 8'h01, 8'(step));
    chk("inc_up", 8'h01, 8'(up));
    dec(8'h1F);
    chk("pd_noeff", 8'h01, 8'(noeff));
    chk("pd_illegal", 8'h00, 8'(illegal));
  endtask
  task automatic t_illegal_stall();
    dec(8'hFF);
    chk("unloaded", 8'h01, 8'(illegal));
    chk("unl_class", 8'h00, 8'(cls));
    stall = 4'h5; dec(8'h07);
    chk("stall_edges", 8'h08, n[7:0]);
    chk("stall_src", 8'h02, 8'(mdsrc));
    stall = 4'h0;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1; reset_n = 1;
    chk("rst_ready", 8'h01, 8'(fetch_ready));
    chk("rst_valid", 8'h00, 8'(decode_valid));
    t_lengths();
    t_variants();
    t_illegal_stall();
    test_done();
  end
endmodule
